/* File: pir_motion_pkg.sv */
// Shared constants and types for the motion sensor configuration block.
package pir_motion_pkg;

  // ---------------------------------------------------------------------
  // Configuration word layout
  // ---------------------------------------------------------------------
  localparam int CFG_WIDTH          = 25;
  localparam int THRESHOLD_LSB      = 17;
  localparam int BLIND_LSB          = 13;
  localparam int PULSES_LSB         = 11;
  localparam int WINDOW_LSB         = 9;
  localparam int MODE_LSB           = 7;
  localparam int SOURCE_LSB         = 5;
  localparam int RESERVED_LSB       = 0;
  localparam logic [4:0] RESERVED_VALUE = 5'h10;
  localparam logic [CFG_WIDTH-1:0] CFG_RESET = 25'h0000000;

  typedef struct packed {
    logic [7:0] threshold;
    logic [3:0] blind_time;
    logic [1:0] pulse_count;
    logic [1:0] window_time;
    logic [1:0] op_mode;
    logic [1:0] source;
    logic [4:0] reserved;
  } motion_config_t;

  typedef enum logic [1:0] {
    MODE_FORCED    = 2'h0,
    MODE_PERIODIC  = 2'h1,
    MODE_WAKE_UP   = 2'h2,
    MODE_RESERVED  = 2'h3
  } op_mode_t;

  typedef enum logic [1:0] {
    SRC_BAND_PASS  = 2'h0,
    SRC_LOW_PASS   = 2'h1,
    SRC_RESERVED   = 2'h2,
    SRC_TEMP       = 2'h3
  } source_t;

  // ---------------------------------------------------------------------
  // Sensor sample carrier
  // ---------------------------------------------------------------------
  localparam int SAMPLE_WIDTH = 14;

  typedef struct packed {
    logic                    valid;
    logic [SAMPLE_WIDTH-1:0] band_pass_path;
    logic [SAMPLE_WIDTH-1:0] low_pass_path;
    logic [SAMPLE_WIDTH-1:0] temperature;
  } sensor_samples_t;

  // ---------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------
  localparam int SYS_CLK_HZ          = 50_000_000;
  localparam int CORE_TICK_NS        = 36_000;
  localparam int CORE_TICK_CYCLES    =
    (CORE_TICK_NS * (SYS_CLK_HZ / 1_000_000) + 999) / 1000;
  localparam int BLIND_UNIT_MS       = 500;
  localparam int BLIND_UNIT_CYCLES   = BLIND_UNIT_MS * (SYS_CLK_HZ / 1000);
  localparam int WINDOW_UNIT_MS      = 2000;
  localparam int WINDOW_UNIT_CYCLES  = WINDOW_UNIT_MS * (SYS_CLK_HZ / 1000);
  localparam int PERIODIC_TICKS      = 512;
  localparam int DATA_HOLD_TICKS     = 2;
  localparam int LATCH_IDLE_TICKS    = 16;
  localparam int LATCH_MIN_BITS      = 25;

endpackage : pir_motion_pkg

/* File: core_tick_gen.sv */
// Free-running divider that makes the internal system clock tick.
module core_tick_gen #(
  parameter int DIVIDE = 1800
) (
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // Tick out
  output logic      tick
);

  logic [31:0] count_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      count_q <= 32'h00000000;
    end else if (count_q >= 32'(DIVIDE - 1)) begin
      count_q <= 32'h00000000;
    end else begin
      count_q <= count_q + 32'h00000001;
    end
  end

  assign tick = (count_q == 32'(DIVIDE - 1));

endmodule : core_tick_gen

/* File: pir_motion_config_alarm.sv */
// Configuration register, serial loader and motion alarm of the sensor.
//
// Overview of operation
// R1: Threshold comes from configuration bits 24:17.
// R2: Blind time after readout falls, 0.5s steps.
// R3: Alarm after one plus count sign-changing pulses.
// R4: Window lasts 2s plus 2s times field.
// R5: Mode 0 never raises a readout interrupt.
// R6: Mode 1 interrupts every 512 internal ticks.
// R7: Mode 2 interrupts only on motion criteria.
// R8: Controller never programs mode value 3.
// R9: Source field selects band, low, temperature.
// R10: Wake-up mode needs band or low source.
// R11: Motion always judged on band-pass signal.
// R12: Controller writes 16 into bits 4:0.
// R13: Latch after 25 bits and 16 idle ticks.
// R14: Alarm holds until controller pulls line low.
// R15: Register undefined until first programmed; here reset loads CFG_RESET, all zeros.
module pir_motion_config_alarm #(
  parameter int BLIND_UNIT  = pir_motion_pkg::BLIND_UNIT_CYCLES,
  parameter int WINDOW_UNIT = pir_motion_pkg::WINDOW_UNIT_CYCLES,
  parameter int TICK_DIVIDE = pir_motion_pkg::CORE_TICK_CYCLES
) (
  // Clock and reset
  input  wire logic                                 sys_clk,
  input  wire logic                                 nrst,
  // Configuration serial input
  input  wire logic                                 config_serial_input,
  // Readout line, open-drain style
  input  wire logic                                 readout_in,
  output logic                                      readout_out,
  output logic                                      readout_oe_n,
  // Sensor samples
  input  wire pir_motion_pkg::sensor_samples_t      samples,
  // Register view, selected data and blind-time flag
  output pir_motion_pkg::motion_config_t            motion_configuration,
  output logic [pir_motion_pkg::SAMPLE_WIDTH-1:0]   source_data_q,
  output logic                                      blind_active
);

  // ---------------------------------------------------------------------
  // Internal system clock tick
  // ---------------------------------------------------------------------
  logic core_tick;

  core_tick_gen #(
    .DIVIDE (TICK_DIVIDE)
  ) u_tick (
    .sys_clk (sys_clk),
    .nrst    (nrst),
    .tick    (core_tick)
  );

  // ---------------------------------------------------------------------
  // Serial configuration loader
  // ---------------------------------------------------------------------
  // The register holds garbage-free zeros here only so that simulation is
  // deterministic; software must still program it before use.
  pir_motion_pkg::motion_config_t cfg_q;
  logic [pir_motion_pkg::CFG_WIDTH-1:0] shift_q;
  logic [5:0]                           bits_q;
  logic [4:0]                           idle_q;
  logic [1:0]                           hold_q;
  logic                                 sampling_q;
  logic                                 config_serial_input_prev_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      config_serial_input_prev_q <= 1'b0;
    end else begin
      config_serial_input_prev_q <= config_serial_input;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      shift_q    <= pir_motion_pkg::CFG_RESET;
      bits_q     <= 6'h00;
      hold_q     <= 2'h0;
      sampling_q <= 1'b0;
      idle_q     <= 5'h00;
    end else if (config_serial_input && !config_serial_input_prev_q && !sampling_q) begin
      sampling_q <= 1'b1;
      hold_q     <= 2'h0;
      idle_q     <= 5'h00;
    end else if (sampling_q) begin
      if (core_tick) begin
        // Bit value is taken once it has stood for two internal ticks.
        if (hold_q == 2'(pir_motion_pkg::DATA_HOLD_TICKS - 1)) begin
          shift_q    <= {shift_q[pir_motion_pkg::CFG_WIDTH-2:0],
                         config_serial_input};
          sampling_q <= 1'b0;
          if (bits_q != 6'h3F) begin
            bits_q <= bits_q + 6'h01;
          end
        end else begin
          hold_q <= hold_q + 2'h1;
        end
      end
    end else if (core_tick && !config_serial_input) begin
      if (idle_q > 5'(pir_motion_pkg::LATCH_IDLE_TICKS)) begin
        bits_q <= 6'h00;
      end else begin
        idle_q <= idle_q + 5'h01;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      cfg_q <= pir_motion_pkg::CFG_RESET; // R15
    end else if (!sampling_q && core_tick && !config_serial_input &&
                 idle_q > 5'(pir_motion_pkg::LATCH_IDLE_TICKS) &&
                 bits_q >= 6'(pir_motion_pkg::LATCH_MIN_BITS)) begin
      cfg_q <= shift_q; // R13
    end
  end

  assign motion_configuration = cfg_q;

  // ---------------------------------------------------------------------
  // Source selection
  // ---------------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      source_data_q <= '0;
    end else if (samples.valid) begin
      if (cfg_q.source == pir_motion_pkg::SRC_BAND_PASS) begin // R9
        source_data_q <= samples.band_pass_path;
      end else if (cfg_q.source == pir_motion_pkg::SRC_LOW_PASS) begin
        source_data_q <= samples.low_pass_path;
      end else if (cfg_q.source == pir_motion_pkg::SRC_TEMP) begin
        source_data_q <= samples.temperature;
      end else begin
        source_data_q <= '0;
      end
    end
  end

  // ---------------------------------------------------------------------
  // Readout line edges and blind time
  // ---------------------------------------------------------------------
  logic        line_prev_q;
  logic        line_fall;
  logic [31:0] blind_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      line_prev_q <= 1'b1;
    end else begin
      line_prev_q <= readout_in;
    end
  end

  assign line_fall = line_prev_q && !readout_in;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      blind_q <= 32'h00000000;
    end else if (line_fall) begin
      blind_q <= 32'((32'(cfg_q.blind_time) + 32'h1) * 32'(BLIND_UNIT)); // R2
    end else if (blind_q != 32'h00000000) begin
      blind_q <= blind_q - 32'h00000001;
    end
  end

  assign blind_active = (blind_q != 32'h00000000);

  // ---------------------------------------------------------------------
  // Motion criteria on the band-pass path
  // ---------------------------------------------------------------------
  logic signed [pir_motion_pkg::SAMPLE_WIDTH-1:0] bp;
  logic [pir_motion_pkg::SAMPLE_WIDTH-1:0]        bp_mag;
  logic                                           over;
  logic        last_sign_q;
  logic [2:0]  pulses_q;
  logic [31:0] window_q;
  logic        motion_hit;

  assign bp     = samples.band_pass_path; // R11
  assign bp_mag = bp[pir_motion_pkg::SAMPLE_WIDTH-1] ? -bp : bp;
  assign over   = samples.valid && !blind_active &&
                  (bp_mag > {6'h00, cfg_q.threshold}); // R1
  // A pulse counts if none is counted yet or its sign differs from the last counted one.
  assign motion_hit = over && (pulses_q == 3'h0 ||
                      bp[pir_motion_pkg::SAMPLE_WIDTH-1] != last_sign_q) &&
                      (pulses_q + 3'h1 >= {1'b0, cfg_q.pulse_count} + 3'h1);

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pulses_q    <= 3'h0;
      last_sign_q <= 1'b0;
      window_q    <= 32'h00000000;
    end else if (blind_active || motion_hit) begin
      pulses_q <= 3'h0;
      window_q <= 32'h00000000;
    end else if (over && (pulses_q == 3'h0 ||
                 bp[pir_motion_pkg::SAMPLE_WIDTH-1] != last_sign_q)) begin
      pulses_q    <= pulses_q + 3'h1; // R3
      last_sign_q <= bp[pir_motion_pkg::SAMPLE_WIDTH-1];
      if (pulses_q == 3'h0) begin
        window_q <= 32'((32'(cfg_q.window_time) + 32'h1) *
                        32'(WINDOW_UNIT)); // R4
      end
    end else if (window_q == 32'h00000001) begin
      pulses_q <= 3'h0;
      window_q <= 32'h00000000;
    end else if (window_q != 32'h00000000) begin
      window_q <= window_q - 32'h00000001;
    end
  end

  // ---------------------------------------------------------------------
  // Interrupt drive on the readout line
  // ---------------------------------------------------------------------
  // The line is only driven high while an interrupt stands; the controller
  // overrides it low to clear, so the drive drops as soon as low is seen.
  logic [8:0] period_q;
  logic       irq_q;

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      period_q <= 9'h000;
    end else if (core_tick) begin
      period_q <= period_q + 9'h001; // R6
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (cfg_q.op_mode == pir_motion_pkg::MODE_PERIODIC &&
                 core_tick && period_q == 9'(pir_motion_pkg::PERIODIC_TICKS - 1)) begin
      irq_q <= 1'b1; // R6
    end else if (cfg_q.op_mode == pir_motion_pkg::MODE_WAKE_UP &&
                 motion_hit) begin
      irq_q <= 1'b1; // R7
    end else if (irq_q && core_tick && !readout_in && line_prev_q == 1'b0) begin
      irq_q <= 1'b0; // R14
    end else if (cfg_q.op_mode == pir_motion_pkg::MODE_FORCED) begin
      irq_q <= 1'b0; // R5
    end
  end

  assign readout_out  = 1'b1;
  assign readout_oe_n = !(irq_q && readout_in);

endmodule : pir_motion_config_alarm

/* File: pir_motion_chk_sva.sv */
// Checker for the motion configuration and alarm ports.
module pir_motion_chk #(
  parameter int TICK = pir_motion_pkg::CORE_TICK_CYCLES
) (
  // Clock and reset
  input wire logic                            sys_clk,
  input wire logic                            nrst,
  // Serial and readout lines
  input wire logic                            config_serial_input,
  input wire logic                            readout_in,
  input wire logic                            readout_out,
  input wire logic                            readout_oe_n,
  // Data
  input wire pir_motion_pkg::sensor_samples_t samples,
  input wire pir_motion_pkg::motion_config_t  motion_configuration,
  input wire logic [13:0]                     source_data_q,
  input wire logic                            blind_active
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  logic [15:0] low_q;
  logic [13:0] pick;
  always_ff @(posedge sys_clk) begin
    if (!nrst || config_serial_input) low_q <= 16'h0000;
    else if (low_q != 16'hFFFF) low_q <= low_q + 16'h0001;
  end
  always_comb begin
    case (motion_configuration.source)
      2'h0: pick = samples.band_pass_path;
      2'h1: pick = samples.low_pass_path;
      2'h3: pick = samples.temperature;
      default: pick = 14'h0000;
    endcase
  end
  // ------------------------------
  // Alarm line, blind time, latch and source checks
  // ------------------------------
  sequence alarm_up;
    !readout_oe_n && readout_in;
  endsequence
  sequence line_kept;
    readout_in && motion_configuration.op_mode != 2'h0;
  endsequence
  chk_mode0_quiet: assert property (
    motion_configuration.op_mode == 2'h0 &&
    $past(motion_configuration.op_mode) == 2'h0 |-> readout_oe_n)
    else $error("interrupt raised in forced mode");
  chk_drive_high: assert property (readout_out == 1'h1)
    else $error("readout drive value not high");
  chk_oe_on_high: assert property (!readout_in |-> readout_oe_n)
    else $error("device drives while line held low");
  chk_alarm_holds: assert property (
    alarm_up ##1 line_kept |-> !readout_oe_n)
    else $error("alarm dropped without a clear");
  chk_blind_start: assert property (
    $fell(readout_in) |=> ##1 blind_active [*8])
    else $error("blind time not started by line fall");
  chk_blind_mute: assert property (
    blind_active && $past(blind_active) && readout_oe_n &&
    motion_configuration.op_mode == 2'h2 |=> readout_oe_n)
    else $error("alarm raised during blind time");
  // Sixteen idle ticks are at least fifteen full tick periods low.
  chk_latch_idle: assert property (
    $changed(motion_configuration) |-> low_q >= 16'(15 * TICK))
    else $error("configuration latched before idle time");
  chk_source_pick: assert property (
    samples.valid |=> source_data_q == $past(pick))
    else $error("selected sample wrong");
endmodule : pir_motion_chk

bind pir_motion_config_alarm pir_motion_chk #(.TICK(TICK_DIVIDE))
  pir_motion_chk_i (
  .sys_clk(sys_clk), .nrst(nrst), .config_serial_input(config_serial_input),
  .readout_in(readout_in), .readout_out(readout_out),
  .readout_oe_n(readout_oe_n), .samples(samples),
  .motion_configuration(motion_configuration),
  .source_data_q(source_data_q), .blind_active(blind_active));

/* File: mcu_model.sv */
// Host controller model driving the serial input and the readout line.
module mcu_model #(
  parameter int TICK = pir_motion_pkg::CORE_TICK_CYCLES
) (
  // Clock
  input  wire logic sys_clk,
  // Lines toward the device
  output logic      config_serial_input,
  output logic      readout_level,
  input  wire logic readout_out,
  input  wire logic readout_oe_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic host_low = 1'b0;
  initial config_serial_input = 1'b0;
  // The line has a pull-up; the device only ever drives it high.
  assign readout_level = host_low ? 1'b0 : (readout_oe_n ? 1'b1 : readout_out);
  // ------------------------------
  // Serial word, most significant bit first
  // ------------------------------
  // Each bit stands two tick periods and a margin after its rising edge.
  task automatic send_word(input logic [25:0] w);
    for (int i = 25; i >= 0; i--) begin
      @(posedge sys_clk) #1 config_serial_input = 1'b0;
      @(posedge sys_clk) #1 config_serial_input = 1'b1;
      @(posedge sys_clk) #1 config_serial_input = w[i];
      repeat (2 * TICK + 100) @(posedge sys_clk);
    end
    @(posedge sys_clk) #1 config_serial_input = 1'b0;
    repeat (20 * TICK) @(posedge sys_clk);
  endtask : send_word
  task automatic sink(input logic v);
    @(posedge sys_clk) #1 host_low = v;
  endtask : sink
endmodule : mcu_model

/* File: pir_motion_config_alarm_bench.sv */
// Self-checking bench for the motion configuration and alarm block.
module pir_motion_config_alarm_bench;
  timeunit 1ns;
  timeprecision 1ns;
  // A short internal tick keeps each serial load brief.
  localparam int TICK = 40;
  // Cycles between two periodic alarms, less the clear sequence between.
  localparam int SPACING = pir_motion_pkg::PERIODIC_TICKS * TICK - 84;
  typedef struct packed {
    logic [13:0] bp;
    logic [13:0] lp;
    logic        oe_n;
  } row_t;
  logic                            sys_clk = 1'b0;
  logic                            nrst = 1'b0;
  logic                            config_serial_input, readout_in;
  logic                            readout_out, readout_oe_n, blind_active;
  logic [13:0]                     source_data_q;
  pir_motion_pkg::sensor_samples_t samples = '0;
  pir_motion_pkg::motion_config_t  motion_configuration, cfg;
  int                              err_total = 0;
  int                              check_count = 0;
  int                              n = 0;
  // Low-pass is big where band-pass is small: only band-pass may alarm.
  row_t rows [4] = '{{14'h0010, 14'h0200, 1'b1}, {14'h0064, 14'h0001, 1'b1},
                     {14'h0070, 14'h0003, 1'b1}, {14'h3F9C, 14'h0002, 1'b0}};
  pir_motion_config_alarm #(.BLIND_UNIT(50), .WINDOW_UNIT(200),
    .TICK_DIVIDE(TICK))
    pir_motion_config_alarm_i (.sys_clk(sys_clk), .nrst(nrst),
    .config_serial_input(config_serial_input), .readout_in(readout_in),
    .readout_out(readout_out), .readout_oe_n(readout_oe_n),
    .samples(samples), .motion_configuration(motion_configuration),
    .source_data_q(source_data_q), .blind_active(blind_active));
  mcu_model #(.TICK(TICK)) mcu_model_i (.sys_clk(sys_clk),
    .config_serial_input(config_serial_input), .readout_level(readout_in),
    .readout_out(readout_out), .readout_oe_n(readout_oe_n));
  initial forever #10 sys_clk = ~sys_clk;
  // ------------------------------
  // Compare and report
  // ------------------------------
  task automatic final_report();
    if (err_total == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report
  task automatic cmp_vec(input logic [24:0] got, input logic [24:0] exp,
                         input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : cmp_vec
  task automatic cmp_bit(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %0t %s", $time, what);
    end
  endtask : cmp_bit
  task automatic wait_alarm(output int cycles);
    cycles = 0;
    while (readout_oe_n !== 1'b0 && cycles < 21000) begin
      @(posedge sys_clk) #1 cycles++;
    end
  endtask : wait_alarm
  initial begin
    repeat (90000) @(posedge sys_clk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (6) @(posedge sys_clk);
    #1 nrst = 1'b1;
    cmp_vec(motion_configuration, pir_motion_pkg::CFG_RESET, "reset cfg");
    cmp_bit(readout_oe_n, 1'b1, "reset line");
    cmp_bit(blind_active, 1'b0, "reset blind");
    cfg = {8'h40, 4'h1, 2'h1, 2'h0, 2'h2, 2'h1, 5'h10};
    mcu_model_i.send_word({1'b1, cfg});
    #1 cmp_vec(motion_configuration, cfg, "latched word");
    foreach (rows[i]) begin
      @(posedge sys_clk) #1 samples = {1'b1, rows[i].bp, rows[i].lp, 14'h0155};
      @(posedge sys_clk) #1 samples.valid = 1'b0;
      repeat (3) @(posedge sys_clk);
      #1 cmp_vec(25'(source_data_q), 25'(rows[i].lp), "source pick");
      cmp_bit(readout_oe_n, rows[i].oe_n, "alarm level");
    end
    repeat (2000) @(posedge sys_clk);
    #1 cmp_bit(readout_oe_n, 1'b0, "alarm held");
    mcu_model_i.sink(1'b1);
    repeat (2) @(posedge sys_clk);
    #1 cmp_bit(blind_active, 1'b1, "blind start");
    repeat (93) @(posedge sys_clk);
    #1 cmp_bit(blind_active, 1'b1, "blind running");
    repeat (10) @(posedge sys_clk);
    #1 cmp_bit(blind_active, 1'b0, "blind over");
    repeat (3600) @(posedge sys_clk);
    mcu_model_i.sink(1'b0);
    repeat (3) @(posedge sys_clk);
    #1 cmp_bit(readout_oe_n, 1'b1, "alarm cleared");
    cfg = {8'h40, 4'h1, 2'h1, 2'h0, 2'h1, 2'h3, 5'h10};
    mcu_model_i.send_word({1'b1, cfg});
    #1 cmp_vec(motion_configuration, cfg, "periodic word");
    @(posedge sys_clk) #1 samples = {1'b1, 14'h0011, 14'h0022, 14'h0033};
    @(posedge sys_clk) #1 samples.valid = 1'b0;
    #1 cmp_vec(25'(source_data_q), 25'h0000033, "temperature pick");
    mcu_model_i.sink(1'b1);
    repeat (2 * TICK) @(posedge sys_clk);
    mcu_model_i.sink(1'b0);
    wait_alarm(n);
    cmp_bit(n < 21000, 1'b1, "periodic alarm");
    mcu_model_i.sink(1'b1);
    repeat (2 * TICK) @(posedge sys_clk);
    mcu_model_i.sink(1'b0);
    repeat (2) @(posedge sys_clk);
    #1 cmp_bit(readout_oe_n, 1'b1, "periodic cleared");
    wait_alarm(n);
    cmp_vec(25'(n), 25'(SPACING), "periodic spacing");
    cfg = {8'h40, 4'h1, 2'h0, 2'h0, 2'h0, 2'h0, 5'h10};
    mcu_model_i.send_word({1'b1, cfg});
    #1 cmp_vec(motion_configuration, cfg, "forced word");
    cmp_bit(readout_oe_n, 1'b1, "forced quiet");
    @(posedge sys_clk) #1 samples = {1'b1, 14'h0100, 14'h0022, 14'h0033};
    @(posedge sys_clk) #1 samples.valid = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 cmp_vec(25'(source_data_q), 25'h0000100, "band pick");
    cmp_bit(readout_oe_n, 1'b1, "forced no alarm");
    final_report();
  end
endmodule : pir_motion_config_alarm_bench
